// ===== scs_device.sv
// Purpose: Device end: power-up reset, strap capture, serial register
//          port with staged settings and start-up sequencing pulses.
// Assumes: Serial port is SPI only; I2C mode is reported, not served.
// Notes:   All state sits in one struct, registered once per clock.
//
// Implementation choice: register access over the SPI serial port.
`timescale 1ns/1ns
`default_nettype none
module scs_device (
   // Clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        reset_n,
   // Link
   scs_link_if.device                       link,
   // Supply monitors, asynchronous
   input  wire logic                        supply_good_io,
   input  wire logic                        supply_good_core,
   // Strap results
   output logic [scs_pkg::STRAP_W-1:0]      strap_word,
   output logic                             serial_is_i2c,
   output logic [scs_pkg::STRAP_MODE_W-1:0] i2c_addr_low,
   output logic                             eeprom_load_req,
   output logic [scs_pkg::STRAP_LOAD_W-1:0] eeprom_condition,
   output logic                             internal_reset,
   // Sequencing
   output logic                             cal_start,
   output logic [7:0]                       detect_start,
   input  wire logic                        detect_done,
   input  wire logic                        lock_achieved,
   input  wire logic                        mf_sync_request,
   output logic                             lock_enable,
   output logic                             dist_sync,
   output logic [7:0]                       outputs_enabled,
   output logic                             watchdog_enable,
   output logic [7:0]                       irq_mask,
   output logic [7:0]                       irq_mode
);
   import scs_pkg::*;

   typedef struct packed {
      logic [1:0]         sup_s1;
      logic [1:0]         sup_s2;
      logic               sup_ok_d;
      logic               rst_s1;
      logic               rst_s2;
      logic [STRAP_W-1:0] mf_s1;
      logic [STRAP_W-1:0] mf_s2;
      logic [2:0]         sp_s1;  // sclk, csb_n, sdi
      logic [2:0]         sp_s2;
      logic               sclk_d;
      logic [2:0]         por_cnt;
      logic               in_reset_d;
      logic [STRAP_W-1:0] strap;
      logic               eeprom_req;
      logic [4:0]         bit_cnt;
      logic [FRAME_W-2:0] shift;
      logic               rd_phase;
      logic [7:0]         sdo_shift;
      logic               sdo;
      logic [7:0]         sh_sync_cal;
      logic [7:0]         sh_detect;
      logic [7:0]         sh_watchdog;
      logic [7:0]         sh_irq_mask;
      logic [7:0]         sh_irq_mode;
      logic [7:0]         sh_out_en;
      logic [7:0]         sh_dist_auto;
      logic [7:0]         sh_ref_auto;
      logic [7:0]         ac_sync_cal;
      logic [7:0]         ac_watchdog;
      logic [7:0]         ac_irq_mask;
      logic [7:0]         ac_irq_mode;
      logic [7:0]         ac_out_en;
      logic [7:0]         ac_dist_auto;
      logic [7:0]         ac_ref_auto;
      logic               cal_start;
      logic [7:0]         detect_start;
      logic               dist_sync;
      logic               detect_pending;
      logic               lock_en;
      logic               live;
      logic [7:0]         out_drive;
   } scs_dev_state_t;

   scs_dev_state_t r_reg;
   scs_dev_state_t r_next;
   logic           int_rst;
   logic           sclk_rise;
   logic           sclk_fall;
   logic           upd;
   logic [15:0]    rd_addr;
   logic [15:0]    wr_addr;
   logic [7:0]     wr_data;

   // Register read mux, shows what software last wrote
   function automatic logic [7:0] rd_val(input scs_dev_state_t s,
                                         input logic [15:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADDR_SYNC_CAL:    v = s.sh_sync_cal;
         ADDR_PROF_DETECT: v = s.sh_detect;
         ADDR_WATCHDOG:    v = s.sh_watchdog;
         ADDR_IRQ_MASK:    v = s.sh_irq_mask;
         ADDR_IRQ_MODE:    v = s.sh_irq_mode;
         ADDR_OUT_ENABLE:  v = s.sh_out_en;
         ADDR_DIST_AUTO:   v = s.sh_dist_auto;
         ADDR_REF_AUTO:    v = s.sh_ref_auto;
         default:          v = 8'h00; // Update strobe reads back zero
      endcase
      return v;
   endfunction : rd_val

   // Next-state logic for the whole device
   always_comb begin
      r_next = r_reg;
      // Two-flop synchronisers for supply, reset pin, strap and serial inputs
      r_next.sup_s1 = {supply_good_io, supply_good_core};
      r_next.sup_s2 = r_reg.sup_s1;
      r_next.sup_ok_d = &r_reg.sup_s2;
      r_next.rst_s1 = link.reset_pin_n;
      r_next.rst_s2 = r_reg.rst_s1;
      r_next.mf_s1 = link.multifunction_pin_levels;
      r_next.mf_s2 = r_reg.mf_s1;
      r_next.sp_s1 = {link.sclk, link.csb_n, link.sdi};
      r_next.sp_s2 = r_reg.sp_s1;
      r_next.sclk_d = r_reg.sp_s2[2];
      sclk_rise = r_reg.sp_s2[2] & ~r_reg.sclk_d;
      sclk_fall = ~r_reg.sp_s2[2] & r_reg.sclk_d;
      rd_addr = {1'b0, r_reg.shift[INSTR_BITS-2:0]};
      wr_addr = {1'b0, r_reg.shift[FRAME_W-3:8-1]};
      wr_data = {r_reg.shift[6:0], r_reg.sp_s2[0]};
      upd = 1'b0;
      // Pulses last one cycle
      r_next.cal_start = 1'b0;
      r_next.dist_sync = 1'b0;
      r_next.detect_start = 8'h00;
      r_next.eeprom_req = 1'b0;
      if ((&r_reg.sup_s2) && !r_reg.sup_ok_d) begin
         r_next.por_cnt = POR_PULSE_CYC;
      end else if (r_reg.por_cnt != 3'h0) begin
         r_next.por_cnt = r_reg.por_cnt - 3'h1;
      end
      int_rst = (r_reg.por_cnt != 3'h0) | ~r_reg.rst_s2 | ~(&r_reg.sup_s2);
      r_next.in_reset_d = int_rst;
      if (int_rst) begin
         r_next.sh_sync_cal = RST_CONFIG;
         r_next.sh_detect = RST_CONFIG;
         r_next.sh_watchdog = RST_WATCHDOG;
         r_next.sh_irq_mask = RST_IRQ_MASK;
         r_next.sh_irq_mode = RST_IRQ_MODE;
         r_next.sh_out_en = RST_OUT_ENABLE;
         r_next.sh_dist_auto = RST_CONFIG;
         r_next.sh_ref_auto = RST_CONFIG;
         r_next.ac_sync_cal = RST_CONFIG;
         r_next.ac_watchdog = RST_WATCHDOG;
         r_next.ac_irq_mask = RST_IRQ_MASK;
         r_next.ac_irq_mode = RST_IRQ_MODE;
         r_next.ac_out_en = RST_OUT_ENABLE;
         r_next.ac_dist_auto = RST_CONFIG;
         r_next.ac_ref_auto = RST_CONFIG;
         r_next.bit_cnt = 5'h00;
         r_next.sdo = 1'b0;
         r_next.detect_pending = 1'b0;
         r_next.lock_en = 1'b0;
         r_next.live = 1'b0;
      end else begin
         if (r_reg.in_reset_d) begin
            r_next.strap = r_reg.mf_s2;
            r_next.eeprom_req =
               |r_reg.mf_s2[STRAP_LOAD_LSB +: STRAP_LOAD_W];
         end
         // serial port only in SPI mode
         if (r_reg.sp_s2[1] || serial_is_i2c) begin
            r_next.bit_cnt = 5'h00;
            r_next.sdo = 1'b0;
            r_next.rd_phase = 1'b0;
         end else if (sclk_rise && r_reg.bit_cnt < FRAME_BITS) begin
            r_next.shift = {r_reg.shift[FRAME_W-3:0], r_reg.sp_s2[0]};
            r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
            if (r_reg.bit_cnt == FRAME_BITS - 5'h01 && !r_reg.rd_phase) begin
               case (wr_addr)
                  ADDR_UPDATE:      upd = wr_data[UPDATE_BIT];
                  ADDR_SYNC_CAL:    r_next.sh_sync_cal = wr_data;
                  ADDR_PROF_DETECT: r_next.sh_detect = wr_data;
                  ADDR_WATCHDOG:    r_next.sh_watchdog = wr_data;
                  ADDR_IRQ_MASK:    r_next.sh_irq_mask = wr_data;
                  ADDR_IRQ_MODE:    r_next.sh_irq_mode = wr_data;
                  ADDR_OUT_ENABLE:  r_next.sh_out_en = wr_data;
                  ADDR_DIST_AUTO:   r_next.sh_dist_auto = wr_data;
                  ADDR_REF_AUTO:    r_next.sh_ref_auto = wr_data;
                  default:          upd = 1'b0; // Unmapped writes dropped
               endcase
            end
         end else if (sclk_fall && r_reg.bit_cnt == INSTR_BITS) begin
            // Read flag is the first instruction bit
            r_next.rd_phase = r_reg.shift[INSTR_BITS-1];
            if (r_reg.shift[INSTR_BITS-1]) begin
               // MSB goes out now, the rest waits in the shifter
               {r_next.sdo, r_next.sdo_shift} = {rd_val(r_reg, rd_addr), 1'b0};
            end
         end else if (sclk_fall && r_reg.bit_cnt > INSTR_BITS) begin
            r_next.sdo = r_reg.rd_phase & r_reg.sdo_shift[7];
            r_next.sdo_shift = {r_reg.sdo_shift[6:0], 1'b0};
         end
         // auto lock after detection; a new start below wins
         if (r_reg.detect_pending && detect_done) begin
            r_next.detect_pending = 1'b0;
            r_next.lock_en = 1'b1;
         end
         if (upd) begin
            r_next.ac_sync_cal = r_reg.sh_sync_cal;
            r_next.ac_watchdog = r_reg.sh_watchdog;
            r_next.ac_irq_mask = r_reg.sh_irq_mask;
            r_next.ac_irq_mode = r_reg.sh_irq_mode;
            r_next.ac_out_en = r_reg.sh_out_en;
            r_next.ac_dist_auto = r_reg.sh_dist_auto;
            r_next.ac_ref_auto = r_reg.sh_ref_auto;
            // Calibration starts on the set edge only
            r_next.cal_start = r_reg.sh_sync_cal[CAL_BIT]
                             & ~r_reg.ac_sync_cal[CAL_BIT];
            r_next.dist_sync = r_reg.sh_sync_cal[SYNC_BIT]
                             & ~r_reg.ac_sync_cal[SYNC_BIT];
            if (!r_reg.sh_ref_auto[AUTO_BIT]) begin
               r_next.lock_en = 1'b1;
            end else begin
               r_next.detect_start = r_reg.sh_detect;
               r_next.detect_pending = |r_reg.sh_detect;
            end
         end
         if (r_reg.dist_sync || mf_sync_request
             || (r_reg.ac_dist_auto[AUTO_BIT] && lock_achieved)) begin
            r_next.live = 1'b1;
         end
      end
      r_next.out_drive = r_reg.live ? r_reg.ac_out_en : 8'h00;
   end

   // Single state register, synchronous reset
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         r_reg <= '0;
         r_reg.in_reset_d <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign link.mf_dev_out = '0;
   assign link.mf_dev_oe  = '0; // Pin functions are not programmable here
   assign link.sdo        = r_reg.sdo;
   assign strap_word       = r_reg.strap;
   assign serial_is_i2c    = |r_reg.strap[STRAP_MODE_LSB +: STRAP_MODE_W];
   assign i2c_addr_low     = r_reg.strap[STRAP_MODE_LSB +: STRAP_MODE_W];
   assign eeprom_load_req  = r_reg.eeprom_req;
   assign eeprom_condition = r_reg.strap[STRAP_LOAD_LSB +: STRAP_LOAD_W];
   assign internal_reset   = int_rst;
   assign cal_start        = r_reg.cal_start;
   assign detect_start     = r_reg.detect_start;
   assign lock_enable      = r_reg.lock_en;
   assign dist_sync        = r_reg.dist_sync;
   assign outputs_enabled  = r_reg.out_drive;
   assign watchdog_enable  = r_reg.ac_watchdog[AUTO_BIT];
   assign irq_mask         = r_reg.ac_irq_mask;
   assign irq_mode         = r_reg.ac_irq_mode;
endmodule : scs_device
`default_nettype wire

// ===== scs_host.sv
// Purpose: Host end: Wishbone-controlled SPI master, strap resistor
//          pattern and reset pin drive.
// Assumes: Device is strapped for SPI; sclk made by a divider.
// Notes:   One serial frame at a time; a busy frame refuses commands.
`timescale 1ns/1ns
`default_nettype none
module scs_host (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // Link
   scs_link_if.host         link,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);
   import scs_pkg::*;

   typedef struct packed {
      logic               ack;
      logic [31:0]        dat;
      logic               busy;
      logic               csb_n;
      logic               sclk;
      logic               sdi;
      logic [3:0]         div;
      logic [4:0]         cnt;
      logic [FRAME_W-1:0] tx;
      logic [7:0]         rx;
      logic [7:0]         rdata;
      logic [STRAP_W-1:0] strap;
      logic               rst_req;
      logic               sdo_s1;
      logic               sdo_s2;
   } scs_host_state_t;

   scs_host_state_t h_reg;
   scs_host_state_t h_next;
   logic            req;
   logic            tick;

   // Bus slave and serial engine
   always_comb begin
      h_next = h_reg;
      h_next.sdo_s1 = link.sdo;
      h_next.sdo_s2 = h_reg.sdo_s1;
      req = wb_cyc_i & wb_stb_i & ~h_reg.ack;
      h_next.ack = req;
      tick = h_reg.div == SCLK_HALF_CYC - 4'h1;
      if (req) begin
         case (wb_adr_i)
            WB_STATUS: h_next.dat = {16'h0000, h_reg.rdata,
                                     7'h00, h_reg.busy};
            WB_BOARD:  h_next.dat = {23'h000000, h_reg.rst_req,
                                     h_reg.strap};
            default:   h_next.dat = 32'h00000000;
         endcase
         if (wb_we_i && wb_adr_i == WB_BOARD) begin
            h_next.strap = wb_dat_i[STRAP_W-1:0];
            h_next.rst_req = wb_dat_i[BOARD_RESET_BIT];
         end
         if (wb_we_i && wb_adr_i == WB_CMD && !h_reg.busy) begin
            h_next.tx = {wb_dat_i[CMD_READ_BIT], wb_dat_i[14:0],
                         wb_dat_i[CMD_WDATA_LSB +: 8]};
            h_next.sdi = wb_dat_i[CMD_READ_BIT];
            h_next.busy = 1'b1;
            h_next.csb_n = 1'b0;
            h_next.sclk = 1'b0;
            h_next.div = 4'h0;
            h_next.cnt = 5'h00;
         end
      end
      if (h_reg.busy && !req) begin
         h_next.div = tick ? 4'h0 : h_reg.div + 4'h1;
         if (tick && h_reg.csb_n) begin
            h_next.busy = 1'b0; // Gap with chip select high is over
         end else if (tick && !h_reg.sclk) begin
            h_next.sclk = 1'b1;
            h_next.rx = {h_reg.rx[6:0], h_reg.sdo_s2};
            h_next.cnt = h_reg.cnt + 5'h01;
         end else if (tick) begin
            h_next.sclk = 1'b0;
            if (h_reg.cnt == FRAME_BITS) begin
               h_next.csb_n = 1'b1;
               h_next.rdata = h_reg.rx;
            end else begin
               h_next.tx = {h_reg.tx[FRAME_W-2:0], 1'b0};
               h_next.sdi = h_reg.tx[FRAME_W-2];
            end
         end
      end
   end

   // Single state register, synchronous reset
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         h_reg <= '0;
         h_reg.csb_n <= 1'b1;
      end else begin
         h_reg <= h_next;
      end
   end

   assign link.sclk        = h_reg.sclk;
   assign link.csb_n       = h_reg.csb_n;
   assign link.sdi         = h_reg.sdi;
   assign link.reset_pin_n = ~h_reg.rst_req;
   assign link.mf_board    = h_reg.strap;
   assign wb_dat_o         = h_reg.dat;
   assign wb_ack_o         = h_reg.ack;
endmodule : scs_host
`default_nettype wire

// ===== scs_link_if.sv
// Purpose: Link between host controller and device: serial port, strap
//          pins and reset pin.
// Assumes: Strap pins resolve from device enable, else board level.
// Notes:   No clocking block; both ends sample through synchronisers.
`timescale 1ns/1ns
`default_nettype none
interface scs_link_if;
   import scs_pkg::*;
   logic                sclk;
   logic                csb_n;
   logic                sdi;
   logic                sdo;
   logic                reset_pin_n;
   logic [STRAP_W-1:0]  mf_board;
   logic [STRAP_W-1:0]  mf_dev_out;
   logic [STRAP_W-1:0]  mf_dev_oe;
   logic [STRAP_W-1:0]  multifunction_pin_levels;

   // Wire level: device drive wins where enabled, else resistor pattern
   assign multifunction_pin_levels = (mf_dev_oe & mf_dev_out)
                                   | (~mf_dev_oe & mf_board);

   modport device (input sclk, csb_n, sdi, reset_pin_n,
                   input multifunction_pin_levels,
                   output sdo, mf_dev_out, mf_dev_oe);
   modport host (output sclk, csb_n, sdi, reset_pin_n, mf_board,
                 input sdo);
endinterface : scs_link_if
`default_nettype wire

// ===== scs_link_sva.sv
// Purpose: Assertions on the serial link and strap pins.
// Assumes: One clock domain; reset_n synchronous, low active.
// Notes:   Sees link signals only; device outputs are left to the bench.
`timescale 1ns/1ns
`default_nettype none
module scs_link_sva (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       reset_n,
   // Link signals
   input wire logic       sclk,
   input wire logic       csb_n,
   input wire logic       sdi,
   input wire logic       reset_pin_n,
   input wire logic [7:0] mf_board,
   input wire logic [7:0] mf_dev_oe,
   input wire logic [7:0] multifunction_pin_levels
);
   logic       sclk_reg;
   logic [5:0] rise_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Rises per frame; cleared while deselected so a short frame shows
   always_ff @(posedge sys_clk) begin
      sclk_reg <= sclk;
      if (!reset_n || csb_n)
         rise_reg <= 6'h00;
      else if (sclk && !sclk_reg)
         rise_reg <= rise_reg + 6'h01;
   end
   a_pins_float: assert property (mf_dev_oe == 8'h00)
      else $error("device drives a strap pin");
   a_pins_follow: assert property (multifunction_pin_levels == mf_board)
      else $error("strap pins differ from board pattern");
   a_frame_bits: assert property ($rose(csb_n) |-> rise_reg == 6'h18)
      else $error("frame without 24 clock rises");
   a_first_rise: assert property ($fell(csb_n) |-> !sclk [*7])
      else $error("first serial rise too early");
   a_high_half: assert property ($rose(sclk) |=> sclk [*7])
      else $error("serial clock high phase too short");
   a_data_stable: assert property (!csb_n && sclk && $past(sclk)
      |-> $stable(sdi))
      else $error("serial data moved while clock high");
   a_select_gap: assert property ($rose(csb_n) |=> csb_n [*7])
      else $error("select gap shorter than eight cycles");
   a_clock_idle: assert property (csb_n [*8] |-> !sclk)
      else $error("serial clock runs outside a frame");
   cover property ($rose(csb_n));
   cover property (!reset_pin_n);
   cover property (mf_board != 8'h00);
endmodule : scs_link_sva
`default_nettype wire

// ===== scs_pkg.sv
// Purpose: Shared constants for the start-up strap and config sequencer.
// Assumes: sys_clk at 10 MHz, serial frame of 24 bits, MSB first.
// Notes:   Both ends and the link interface import this package.
package scs_pkg;
   // Device register offsets on the serial port
   localparam logic [15:0] ADDR_UPDATE      = 16'h0005;
   localparam logic [15:0] ADDR_SYNC_CAL    = 16'h0a02;
   localparam logic [15:0] ADDR_PROF_DETECT = 16'h0a0d;
   localparam logic [15:0] ADDR_WATCHDOG    = 16'h0200;
   localparam logic [15:0] ADDR_IRQ_MASK    = 16'h0201;
   localparam logic [15:0] ADDR_IRQ_MODE    = 16'h0202;
   localparam logic [15:0] ADDR_OUT_ENABLE  = 16'h0400;
   localparam logic [15:0] ADDR_DIST_AUTO   = 16'h0401;
   localparam logic [15:0] ADDR_REF_AUTO    = 16'h0500;
   // Bit positions
   localparam int UPDATE_BIT = 0;
   localparam int CAL_BIT    = 0;
   localparam int SYNC_BIT   = 1;
   localparam int AUTO_BIT   = 0;
   // Reset values; irq mode 0 means open-drain NMOS
   localparam logic [7:0] RST_WATCHDOG   = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK   = 8'h00;
   localparam logic [7:0] RST_IRQ_MODE   = 8'h00;
   localparam logic [7:0] RST_OUT_ENABLE = 8'h00;
   localparam logic [7:0] RST_CONFIG     = 8'h00;
   // Strap word fields
   localparam int STRAP_MODE_LSB  = 0;
   localparam int STRAP_MODE_W    = 3;
   localparam int STRAP_LOAD_LSB  = 3;
   localparam int STRAP_LOAD_W    = 5;
   localparam int STRAP_W         = 8;
   // Serial frame: read flag, 15 address bits, 8 data bits
   localparam logic [4:0] INSTR_BITS = 5'h10;
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam int         FRAME_W    = 24;
   // Timing
   localparam int SYS_PERIOD_NS = 100;
   localparam int POR_PULSE_NS  = 75;
   localparam int HIZ_LIMIT_NS  = 45;
   localparam int POR_CYC_I = (POR_PULSE_NS + SYS_PERIOD_NS - 1)
                              / SYS_PERIOD_NS;
   localparam logic [2:0] POR_PULSE_CYC = 3'(POR_CYC_I < 1 ? 1 : POR_CYC_I);
   localparam int HIZ_CYC_I = HIZ_LIMIT_NS / SYS_PERIOD_NS;
   localparam int HIZ_LIMIT_CYC = HIZ_CYC_I < 1 ? 1 : HIZ_CYC_I;
   localparam logic [3:0] SCLK_HALF_CYC = 4'h8;
   // Host wishbone map
   localparam logic [3:0] WB_CMD    = 4'h0;
   localparam logic [3:0] WB_STATUS = 4'h4;
   localparam logic [3:0] WB_BOARD  = 4'h8;
   localparam int CMD_WDATA_LSB   = 16;
   localparam int CMD_READ_BIT    = 24;
   localparam int STAT_RDATA_LSB  = 8;
   localparam int BOARD_RESET_BIT = 8;
endpackage : scs_pkg

// ===== tb_startup_strap_config_sequencer.sv
// Purpose: Bench for the strap and config sequencer, host and device.
// Assumes: Host end drives the link; straps set through its board reg.
// Notes:   Serial accesses go through the host's Wishbone command reg.
`timescale 1ns/1ns
`default_nettype none
module tb_startup_strap_config_sequencer;
   import scs_pkg::*;
   logic        sys_clk, reset_n, cyc, stb, we, sgi, sgc, dd, la, ms;
   logic        ack, cal, dsy, eld, ir, i2c, lk, wd;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat, q;
   logic [7:0]  sw, det, oen, msk, mode, v8;
   logic [7:0]  seen = 8'h00;
   logic [7:0]  pat [3] = '{8'h05, 8'ha8, 8'h18};
   logic [2:0]  alo;
   logic [4:0]  cond;
   int          bad_count = 0, n_tests = 0, n_cal = 0, n_dsy = 0, n_eld = 0;
   scs_link_if link ();
   scs_host i_scs_host (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
   scs_device i_scs_device (.sys_clk(sys_clk), .reset_n(reset_n),
      .link(link), .supply_good_io(sgi), .supply_good_core(sgc),
      .strap_word(sw), .serial_is_i2c(i2c), .i2c_addr_low(alo),
      .eeprom_load_req(eld), .eeprom_condition(cond),
      .internal_reset(ir), .cal_start(cal), .detect_start(det),
      .detect_done(dd), .lock_achieved(la), .mf_sync_request(ms),
      .lock_enable(lk), .dist_sync(dsy), .outputs_enabled(oen),
      .watchdog_enable(wd), .irq_mask(msk), .irq_mode(mode));
   scs_link_sva i_scs_link_sva (.sys_clk(sys_clk), .reset_n(reset_n),
      .sclk(link.sclk), .csb_n(link.csb_n), .sdi(link.sdi),
      .reset_pin_n(link.reset_pin_n), .mf_board(link.mf_board),
      .mf_dev_oe(link.mf_dev_oe),
      .multifunction_pin_levels(link.multifunction_pin_levels));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Pulses stand one cycle, so count them at every edge
   always @(posedge sys_clk) begin
      n_cal <= n_cal + int'(cal === 1'b1);
      n_dsy <= n_dsy + int'(dsy === 1'b1);
      n_eld <= n_eld + int'(eld === 1'b1);
      if (det !== 8'h00)
         seen <= det;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // One classic cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge sys_clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      {cyc, stb} <= 2'b00;
      if (n >= 20 || r[0] === 1'bx && a == WB_STATUS) begin
         bad_count++;
         complete_run();
      end
   endtask : wb
   // Serial frame through the host, then poll until not busy
   task automatic ser(input logic rd, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] v);
      logic [31:0] r;
      int n;
      wb(1'b1, WB_CMD, {7'h00, rd, d, 1'b0, a[14:0]}, r);
      n = 0;
      do begin
         wb(1'b0, WB_STATUS, 32'h0, r);
         n++;
      end while (r[0] !== 1'b0 && n < 300);
      v = r[15:8];
      if (n >= 300) begin
         bad_count++;
         complete_run();
      end
   endtask : ser
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] v;
      ser(1'b0, a, d, v);
   endtask : wr
   initial begin
      {reset_n, cyc, stb, we, sgi, sgc, dd, la, ms} = 9'h000;
      {adr, sel, wdat} = {8'h0f, 32'h0};
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(ir, 1'b1);
      sgi <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(ir, 1'b1);
      sgc <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk(ir, 1'b0);
      chk(wd, 1'b0);
      chk({msk, mode}, 16'h0000);
      chk(oen, 8'h00);
      chk(link.mf_dev_oe, 8'h00);
      chk({sw, i2c}, 9'h000);
      $display("test defaults done");
      wr(ADDR_REF_AUTO, 8'h01);
      wr(ADDR_PROF_DETECT, 8'h5a);
      wr(ADDR_UPDATE, 8'h01);
      chk(seen, 8'h5a);
      chk(lk, 1'b0);
      dd <= 1'b1;
      @(posedge sys_clk);
      dd <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(lk, 1'b1);
      $display("test detect done");
      wr(ADDR_WATCHDOG, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h3c);
      wr(ADDR_IRQ_MODE, 8'h01);
      chk({wd, msk}, 9'h000);
      ser(1'b1, ADDR_IRQ_MASK, 8'h00, v8);
      chk(v8, 8'h3c);
      wr(ADDR_UPDATE, 8'h01);
      chk({wd, msk}, 9'h13c);
      chk(mode, 8'h01);
      $display("test update done");
      wr(ADDR_SYNC_CAL, 8'h01);
      chk(n_cal, 0);
      wr(ADDR_UPDATE, 8'h01);
      wr(ADDR_SYNC_CAL, 8'h00);
      wr(ADDR_UPDATE, 8'h01);
      chk(n_cal, 1);
      wr(ADDR_OUT_ENABLE, 8'h0f);
      wr(ADDR_UPDATE, 8'h01);
      chk(oen, 8'h00);
      wr(ADDR_SYNC_CAL, 8'h02);
      wr(ADDR_UPDATE, 8'h01);
      chk(n_dsy, 1);
      chk(oen, 8'h0f);
      $display("test calibrate and sync done");
      foreach (pat[i]) begin
         wb(1'b1, WB_BOARD, {23'h0, 1'b1, pat[i]}, q);
         repeat (4) @(posedge sys_clk);
         chk(ir, 1'b1);
         wb(1'b1, WB_BOARD, {24'h0, pat[i]}, q);
         repeat (8) @(posedge sys_clk);
         chk(sw, pat[i]);
         chk({i2c, alo}, {|pat[i][2:0], pat[i][2:0]});
         chk(cond, pat[i][7:3]);
         wb(1'b1, WB_BOARD, {24'h0, ~pat[i]}, q);
         // Let the new pin levels pass the synchronisers first
         repeat (4) @(posedge sys_clk);
         chk(sw, pat[i]);
      end
      chk(n_eld, 2);
      $display("test straps done");
      // Pin reset cleared live; auto sync must follow lock
      wr(ADDR_OUT_ENABLE, 8'h0f);
      wr(ADDR_DIST_AUTO, 8'h01);
      wr(ADDR_UPDATE, 8'h01);
      chk(oen, 8'h00);
      la <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(oen, 8'h0f);
      $display("test auto sync done");
      complete_run();
   end
endmodule : tb_startup_strap_config_sequencer
`default_nettype wire
